/* File: hdl/touch_consts.vh */
`ifndef TOUCH_CONSTS_VH
`define TOUCH_CONSTS_VH

// register indices on the link register port
`define ADDR_MEASURE_CTRL 7'h74
`define ADDR_TIMING_CTRL 7'h76
`define ADDR_PHYSICAL_CTRL 7'h78
`define ADDR_RESULT 7'h7a

// measure control fields
`define BIT_POLL 9
`define BIT_CONTINUOUS 8
`define BIT_ENABLE_HI 7
`define BIT_ENABLE_LO 1
`define BIT_PAIR 0
`define MEASURE_CTRL_RESET 10'h000

// timing control fields
`define RATE_HI 9
`define RATE_LO 8
`define SETTLE_HI 7
`define SETTLE_LO 4
`define BIT_SLOT_EN 3
`define SLOT_HI 2
`define SLOT_LO 0
`define TIMING_CTRL_RESET 10'h00e
`define SETTLE_NONE 4'hf
`define SLOT_RESERVED 3'h7
`define SLOT_BASE 4'h5

// physical control fields
`define POWER_HI 15
`define POWER_LO 14
`define BIT_WAKE_SCOPE 13
`define BIT_FIVE_WIRE 12
`define BIT_PEN_GATED 11
`define BIT_HOLD_DATA 9
`define POWER_OFF 2'h0
`define POWER_DETECT_WAKE 2'h1
`define POWER_DETECT_ONLY 2'h2
`define POWER_FULL 2'h3

// settling time in link frames per code
`define SETTLE_F0 9'h001
`define SETTLE_F1 9'h002
`define SETTLE_F2 9'h004
`define SETTLE_F3 9'h008
`define SETTLE_F4 9'h010
`define SETTLE_F5 9'h020
`define SETTLE_F6 9'h030
`define SETTLE_F7 9'h040
`define SETTLE_F8 9'h060
`define SETTLE_F9 9'h080
`define SETTLE_FA 9'h0a0
`define SETTLE_FB 9'h0c0
`define SETTLE_FC 9'h0e0
`define SETTLE_FD 9'h100
`define SETTLE_FE 9'h120

// continuous period in 48 kHz link frames
`define RATE_SLOW0 10'h200
`define RATE_SLOW1 10'h190
`define RATE_SLOW2 10'h138
`define RATE_SLOW3 10'h100
`define RATE_FAST0 10'h006
`define RATE_FAST1 10'h004
`define RATE_FAST2 10'h002
`define RATE_FAST3 10'h001

// result source codes
`define SRC_NONE 3'h0

`endif

/* File: hdl/frame_delay.v */
`timescale 1ns/1ns
// counts link frame ticks after a load and pulses done on the last one
module frame_delay (
    input wire ref_clk,
    input wire rst_n,
    input wire load,
    input wire [8:0] frames,
    input wire frame_tick,
    output reg done
);
    reg [8:0] count_q;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= 9'h000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (load) begin
                count_q <= frames;
            end else if (frame_tick && count_q != 9'h000) begin
                count_q <= count_q - 9'h001;
                if (count_q == 9'h001) begin
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: hdl/touchpanel_measure_control.v */
`timescale 1ns/1ns
`include "touch_consts.vh"

// Contract
// - with continuous mode off, writing one to poll starts one measurement.
// - mode bit clear converts on poll only; set converts continuously.
// - bits 7 to 1 enable aux4..aux1, pressure, Y, X; all reset off.
// - pair mode clear gives one measurement per trigger; set gives paired set.
// - continuous rate field picks the period; fast set when settle code all ones.
// - settle field waits 1 to 288 link frames; code 1111 no wait, switches held at full digitiser power.
// - slot readback enable resets set; cleared, results only via register map.
// - slot field picks link slots 5 to 11, reset slot 11, 111 reserved.
// - power field: off, detect with wake, detect without wake, full digitiser.
// - wake scope clear wakes link only; set wakes link and whole device.
// - panel type bit clear four-wire, set five-wire switch sequencing.
// - result register holds pen state, source code and twelve-bit value.
// - hold-data set keeps the result until the host has read it.
// - pen gating set starts measurements only while the pen is down.
module touchpanel_measure_control (
    input wire ref_clk,
    input wire rst_n,
    input wire reg_wr_stb,
    input wire reg_rd_stb,
    input wire [6:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire link_sync,
    input wire pen_down_pin,
    output reg conv_start,
    output reg [2:0] conv_source,
    input wire conv_done,
    input wire [11:0] conv_value,
    output wire switch_matrix_hold,
    output wire panel_five_wire,
    output wire pen_detect_en,
    output wire digitiser_en,
    output reg wake_link,
    output reg wake_device,
    output reg slot_valid,
    output reg [3:0] slot_number,
    output reg [15:0] slot_data
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SETTLE = 3'b010;
    localparam [2:0] ST_CONVERT = 3'b100;

    function [8:0] settle_frames;
        input [3:0] code;
        begin
            case (code)
                4'h0: settle_frames = `SETTLE_F0;
                4'h1: settle_frames = `SETTLE_F1;
                4'h2: settle_frames = `SETTLE_F2;
                4'h3: settle_frames = `SETTLE_F3;
                4'h4: settle_frames = `SETTLE_F4;
                4'h5: settle_frames = `SETTLE_F5;
                4'h6: settle_frames = `SETTLE_F6;
                4'h7: settle_frames = `SETTLE_F7;
                4'h8: settle_frames = `SETTLE_F8;
                4'h9: settle_frames = `SETTLE_F9;
                4'ha: settle_frames = `SETTLE_FA;
                4'hb: settle_frames = `SETTLE_FB;
                4'hc: settle_frames = `SETTLE_FC;
                4'hd: settle_frames = `SETTLE_FD;
                4'he: settle_frames = `SETTLE_FE;
                default: settle_frames = 9'h000;
            endcase
        end
    endfunction

    function [9:0] rate_frames;
        input [1:0] code;
        input fast;
        begin
            case ({fast, code})
                3'b000: rate_frames = `RATE_SLOW0;
                3'b001: rate_frames = `RATE_SLOW1;
                3'b010: rate_frames = `RATE_SLOW2;
                3'b011: rate_frames = `RATE_SLOW3;
                3'b100: rate_frames = `RATE_FAST0;
                3'b101: rate_frames = `RATE_FAST1;
                3'b110: rate_frames = `RATE_FAST2;
                default: rate_frames = `RATE_FAST3;
            endcase
        end
    endfunction

    // one-hot of the lowest set bit: x first, aux4 last
    function [6:0] lowest_bit;
        input [6:0] m;
        begin
            lowest_bit = m & (~m + 7'h01);
        end
    endfunction

    function [2:0] source_code;
        input [6:0] one_hot;
        integer i;
        begin
            source_code = `SRC_NONE;
            for (i = 0; i < 7; i = i + 1) begin
                if (one_hot[i]) begin
                    source_code = i[2:0] + 3'h1;
                end
            end
        end
    endfunction

    reg [9:0] measure_ctrl_q;
    reg [9:0] timing_ctrl_q;
    reg [3:0] physical_hi_q;
    reg pen_gated_measure_q;
    reg hold_data_q;
    reg [15:0] result_q;
    reg unread_q;
    reg [2:0] state_q;
    reg [6:0] pending_q;
    reg [6:0] current_q;
    reg [9:0] rate_count_q;
    reg rate_due_q;
    reg sync_meta_q, sync_q, sync_last_q;
    reg pen_meta_q, pen_q, pen_last_q;

    wire frame_tick = sync_q & ~sync_last_q;
    wire poll_bit = measure_ctrl_q[`BIT_POLL];
    wire continuous_mode_sel = measure_ctrl_q[`BIT_CONTINUOUS];
    wire xy_pair_mode = measure_ctrl_q[`BIT_PAIR];
    wire [6:0] meas_enables = measure_ctrl_q[`BIT_ENABLE_HI:`BIT_ENABLE_LO];
    wire [1:0] conversion_rate_sel = timing_ctrl_q[`RATE_HI:`RATE_LO];
    wire [3:0] settle_time_sel = timing_ctrl_q[`SETTLE_HI:`SETTLE_LO];
    wire readback_slot_enable = timing_ctrl_q[`BIT_SLOT_EN];
    wire [2:0] readback_slot_sel = timing_ctrl_q[`SLOT_HI:`SLOT_LO];
    wire [1:0] digitiser_power_state = physical_hi_q[3:2];
    wire pen_wake_scope = physical_hi_q[1];
    wire no_settle = (settle_time_sel == `SETTLE_NONE);

    wire pen_ok = ~pen_gated_measure_q | pen_q;
    wire idle = state_q[0];
    wire poll_go = poll_bit & ~continuous_mode_sel & idle & pen_ok;
    wire cont_go = continuous_mode_sel & rate_due_q & idle & pen_ok;
    // single mode takes only the first enabled source per trigger
    wire [6:0] start_mask = xy_pair_mode ? meas_enables : lowest_bit(meas_enables);
    wire start = (poll_go | cont_go) & (start_mask != 7'h00);
    wire [6:0] next_src = lowest_bit(start ? start_mask : pending_q);
    wire settle_done;
    wire write_measure = reg_wr_stb && reg_addr == `ADDR_MEASURE_CTRL;
    wire read_result = reg_rd_stb && reg_addr == `ADDR_RESULT;
    wire store_ok = ~hold_data_q | ~unread_q;
    wire [15:0] new_result = {pen_q, source_code(current_q), conv_value};

    assign switch_matrix_hold = no_settle & digitiser_en;
    assign panel_five_wire = physical_hi_q[0];
    assign pen_detect_en = (digitiser_power_state != `POWER_OFF);
    assign digitiser_en = (digitiser_power_state == `POWER_FULL);

    frame_delay settle_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(start || (state_q[2] && conv_done)),
        .frames(settle_frames(settle_time_sel)),
        .frame_tick(frame_tick),
        .done(settle_done)
    );

    // link frame sync and pen pin come from outside this clock
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sync_meta_q <= 1'b0;
            sync_q <= 1'b0;
            sync_last_q <= 1'b0;
            pen_meta_q <= 1'b0;
            pen_q <= 1'b0;
            pen_last_q <= 1'b0;
        end else begin
            sync_meta_q <= link_sync;
            sync_q <= sync_meta_q;
            sync_last_q <= sync_q;
            pen_meta_q <= pen_down_pin;
            pen_q <= pen_meta_q;
            pen_last_q <= pen_q;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            measure_ctrl_q <= `MEASURE_CTRL_RESET;
            timing_ctrl_q <= `TIMING_CTRL_RESET;
            physical_hi_q <= 4'h0;
            pen_gated_measure_q <= 1'b0;
            hold_data_q <= 1'b0;
        end else begin
            if (write_measure) begin
                measure_ctrl_q <= reg_wdata[9:0];
            end else if (poll_go) begin
                measure_ctrl_q[`BIT_POLL] <= 1'b0;
            end
            if (reg_wr_stb && reg_addr == `ADDR_TIMING_CTRL) begin
                timing_ctrl_q <= reg_wdata[9:0];
            end
            if (reg_wr_stb && reg_addr == `ADDR_PHYSICAL_CTRL) begin
                physical_hi_q <= reg_wdata[15:12];
                pen_gated_measure_q <= reg_wdata[`BIT_PEN_GATED];
                hold_data_q <= reg_wdata[`BIT_HOLD_DATA];
            end
        end
    end

    // continuous period counted in link frames
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            rate_count_q <= 10'h000;
            rate_due_q <= 1'b0;
        end else if (!continuous_mode_sel) begin
            rate_count_q <= 10'h000;
            rate_due_q <= 1'b0;
        end else begin
            // set wins: a period ending as the last one is taken is not lost
            if (cont_go) begin
                rate_due_q <= 1'b0;
            end
            if (frame_tick) begin
                if (rate_count_q + 10'h001 >= rate_frames(conversion_rate_sel, no_settle)) begin
                    rate_count_q <= 10'h000;
                    rate_due_q <= 1'b1;
                end else begin
                    rate_count_q <= rate_count_q + 10'h001;
                end
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            pending_q <= 7'h00;
            current_q <= 7'h00;
            conv_start <= 1'b0;
            conv_source <= `SRC_NONE;
        end else begin
            conv_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        pending_q <= start_mask & ~next_src;
                        current_q <= next_src;
                        conv_source <= source_code(next_src);
                        if (no_settle) begin
                            conv_start <= 1'b1;
                            state_q <= ST_CONVERT;
                        end else begin
                            state_q <= ST_SETTLE;
                        end
                    end
                end
                ST_SETTLE: begin
                    if (settle_done) begin
                        conv_start <= 1'b1;
                        state_q <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (conv_done) begin
                        if (pending_q == 7'h00) begin
                            state_q <= ST_IDLE;
                        end else begin
                            pending_q <= pending_q & ~next_src;
                            current_q <= next_src;
                            conv_source <= source_code(next_src);
                            if (no_settle) begin
                                conv_start <= 1'b1;
                                state_q <= ST_CONVERT;
                            end else begin
                                state_q <= ST_SETTLE;
                            end
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // results: register map unless hold-data keeps an unread one, link slot when enabled and not 111
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            result_q <= 16'h0000;
            unread_q <= 1'b0;
            slot_valid <= 1'b0;
            slot_number <= 4'h0;
            slot_data <= 16'h0000;
        end else begin
            slot_valid <= 1'b0;
            if (state_q[2] && conv_done) begin
                if (store_ok) begin
                    result_q <= new_result;
                end
                unread_q <= 1'b1;
                if (readback_slot_enable && readback_slot_sel != `SLOT_RESERVED) begin
                    slot_valid <= 1'b1;
                    slot_number <= `SLOT_BASE + {1'b0, readback_slot_sel};
                    slot_data <= new_result;
                end
            end else if (read_result) begin
                unread_q <= 1'b0;
            end
        end
    end

    // a pen-down edge in detect-with-wake power wakes the link, and the device too when scoped so
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_link <= 1'b0;
            wake_device <= 1'b0;
        end else begin
            wake_link <= 1'b0;
            wake_device <= 1'b0;
            if (pen_q && !pen_last_q && digitiser_power_state == `POWER_DETECT_WAKE) begin
                wake_link <= 1'b1;
                wake_device <= pen_wake_scope;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd_stb) begin
            case (reg_addr)
                `ADDR_MEASURE_CTRL: reg_rdata <= {6'h00, measure_ctrl_q};
                `ADDR_TIMING_CTRL: reg_rdata <= {6'h00, timing_ctrl_q};
                `ADDR_PHYSICAL_CTRL: reg_rdata <= {physical_hi_q, pen_gated_measure_q,
                                                   1'b0, hold_data_q, 9'h000};
                // live pen state, held source and value
                `ADDR_RESULT: reg_rdata <= {pen_q, result_q[14:0]};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule

/* File: sim/touch_asserts.sv */
`timescale 1ns/1ns
module touch_asserts (
    input wire ref_clk,
    input wire rst_n,
    input wire reg_wr_stb,
    input wire reg_rd_stb,
    input wire [6:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire conv_start,
    input wire switch_matrix_hold,
    input wire panel_five_wire,
    input wire pen_detect_en,
    input wire digitiser_en,
    input wire wake_link,
    input wire wake_device,
    input wire slot_valid,
    input wire [3:0] slot_number,
    input wire [15:0] slot_data
);
    // shadows follow writes on the same edge as the registers inside
    logic [15:0] tim_q;
    logic [15:0] phy_q;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tim_q <= 16'h000e;
            phy_q <= 16'h0000;
        end else if (reg_wr_stb && reg_addr == 7'h76) begin
            tim_q <= reg_wdata;
        end else if (reg_wr_stb && reg_addr == 7'h78) begin
            phy_q <= reg_wdata;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence wake_ev;
        wake_link ##1 !wake_link;
    endsequence
    sequence rd_measure;
        reg_rd_stb && reg_addr == 7'h74;
    endsequence
    a_detect_power: assert property (pen_detect_en == (phy_q[15:14] != 2'h0))
        else $error("pen detect enable wrong");
    a_digitiser_full: assert property (digitiser_en == (phy_q[15:14] == 2'h3))
        else $error("digitiser enable wrong");
    a_panel_type: assert property (panel_five_wire == phy_q[12])
        else $error("panel type wrong");
    a_switch_hold: assert property (switch_matrix_hold ==
        (tim_q[7:4] == 4'hf && phy_q[15:14] == 2'h3)) else $error("switch hold wrong");
    a_wake_pulse: assert property (wake_link |-> phy_q[15:14] == 2'h1 ##0 wake_ev)
        else $error("wake pulse wrong");
    a_wake_scope: assert property ((wake_link || wake_device) |->
        wake_link && wake_device == phy_q[13]) else $error("wake scope wrong");
    a_conv_pulse: assert property (conv_start |=> !conv_start)
        else $error("conversion start not a pulse");
    a_slot_number: assert property (slot_valid |-> tim_q[2:0] != 3'h7 &&
        slot_number == {1'b0, tim_q[2:0]} + 4'h5) else $error("slot number wrong");
    a_slot_enable: assert property (slot_valid |-> tim_q[3])
        else $error("slot output while disabled");
    a_result_tagged: assert property (slot_valid |-> slot_data[14:12] != 3'h0)
        else $error("result without source");
    a_measure_upper: assert property (rd_measure |=> reg_rdata[15:10] == 6'h00)
        else $error("upper control bits not zero");
endmodule

/* File: sim/link_partner.sv */
`timescale 1ns/1ns
module link_partner (
    input wire ref_clk,
    input wire conv_start,
    output logic link_sync,
    output logic conv_done,
    output logic [11:0] conv_value
);
    integer seed = 40031;
    initial begin
        link_sync = 1'b0;
        forever begin
            #62 link_sync = 1'b1;
            #63 link_sync = 1'b0;
        end
    end
    initial begin
        conv_done = 1'b0;
        conv_value = 12'h000;
        forever begin
            @(posedge ref_clk);
            if (conv_start === 1'b1) begin
                repeat (20) @(posedge ref_clk);
                #1 conv_done = 1'b1;
                conv_value = 12'($random(seed));
                @(posedge ref_clk);
                #1 conv_done = 1'b0;
                // stale data must not look valid after the pulse
                conv_value = ~conv_value;
            end
        end
    end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
    logic ref_clk, rst_n, reg_wr_stb, reg_rd_stb, pen_down_pin, link_sync, conv_start;
    logic conv_done, wake_link, wake_device, slot_valid, switch_matrix_hold;
    logic panel_five_wire, pen_detect_en, digitiser_en;
    logic [6:0] reg_addr, en;
    logic [15:0] reg_wdata, reg_rdata, slot_data;
    logic [2:0] conv_source, lo;
    logic [3:0] slot_number, slot_exp;
    logic [11:0] conv_value, held;
    logic [2:0] src_q[$];
    logic [11:0] val_q[$];
    integer n_mismatch = 0, checked = 0, seed = 40031, i, k, j, n_wake = 0;
    touchpanel_measure_control dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_sync(link_sync),
        .pen_down_pin(pen_down_pin), .conv_start(conv_start), .conv_source(conv_source),
        .conv_done(conv_done), .conv_value(conv_value), .switch_matrix_hold(switch_matrix_hold),
        .panel_five_wire(panel_five_wire), .pen_detect_en(pen_detect_en),
        .digitiser_en(digitiser_en), .wake_link(wake_link), .wake_device(wake_device),
        .slot_valid(slot_valid), .slot_number(slot_number), .slot_data(slot_data));
    link_partner far_u (.ref_clk(ref_clk), .conv_start(conv_start), .link_sync(link_sync),
        .conv_done(conv_done), .conv_value(conv_value));
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_stb = 1'b1;
        @(posedge ref_clk);
        #1 reg_wr_stb = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        reg_addr = a;
        reg_rd_stb = 1'b1;
        @(posedge ref_clk);
        #1 reg_rd_stb = 1'b0;
        @(posedge ref_clk);
        #1 cmp({4'h0, reg_rdata}, {4'h0, e});
    endtask
    // a hang here is a failure, not a silent pass
    task automatic drain(input integer lim);
        i = 0;
        while (src_q.size() != 0 && i < lim) begin
            @(posedge ref_clk);
            i = i + 1;
        end
        if (src_q.size() != 0) cmp(20'h0, 20'hfffff);
        src_q.delete();
        repeat (30) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_vals(input integer n);
        i = 0;
        while (val_q.size() < n && i < 2000) begin
            @(posedge ref_clk);
            i = i + 1;
        end
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task report_and_stop;
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        if (conv_done === 1'b1) val_q.push_back(conv_value);
        if (slot_valid === 1'b1) begin
            if (src_q.size() == 0 || val_q.size() == 0) cmp(20'h0, 20'hfffff);
            else cmp({slot_number, slot_data},
                {slot_exp, pen_down_pin, src_q.pop_front(), val_q.pop_front()});
        end
        if (wake_link === 1'b1 && wake_device === 1'b1) n_wake = n_wake + 1;
        if (conv_start === 1'b1 && src_q.size() != 0)
            cmp({17'h0, conv_source}, {17'h0, src_q[0]});
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #300000 n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
        pen_down_pin = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        rd(7'h74, 16'h0000);
        rd(7'h76, 16'h000e);
        rd(7'h78, 16'h0000);
        rd(7'h7a, 16'h0000);
        rd(7'h20, 16'h0000);
        // single mode: lowest enabled source only, slot codes 0 to 6 in turn
        for (k = 0; k < 7; k = k + 1) begin
            wr(7'h76, 16'h00f8 | k[15:0]);
            slot_exp = 4'h5 + k[3:0];
            en = 7'($random(seed));
            if (en == 7'h00) en = 7'h01;
            lo = 3'h0;
            for (j = 6; j >= 0; j = j - 1) if (en[j]) lo = j[2:0] + 3'h1;
            src_q.push_back(lo);
            wr(7'h74, {7'h01, 1'b0, en, 1'b0});
            drain(500);
            rd(7'h74, {7'h00, 1'b0, en, 1'b0});
        end
        // pair mode with all sources, eight-frame settle, then the longest settle
        wr(7'h76, 16'h003e);
        for (k = 1; k < 8; k = k + 1) src_q.push_back(k[2:0]);
        wr(7'h74, 16'h02ff);
        drain(4000);
        wr(7'h76, 16'h00ee);
        src_q.push_back(3'h1);
        wr(7'h74, 16'h0202);
        drain(6000);
        // hold keeps the first unread result; slot output off
        val_q.delete();
        // earlier results are still unread, so the first one lands before hold is set
        wr(7'h76, 16'h00f6);
        wr(7'h74, 16'h0202);
        wait_vals(1);
        held = val_q[0];
        wr(7'h78, 16'h0200);
        wr(7'h74, 16'h0204);
        wait_vals(2);
        rd(7'h7a, {4'h1, held});
        rd(7'h7a, {4'h1, held});
        wr(7'h78, 16'h0000);
        wr(7'h74, 16'h0204);
        wait_vals(3);
        rd(7'h7a, {4'h2, val_q[2]});
        val_q.delete();
        // pen gating stalls the poll until pen down, which also wakes
        wr(7'h76, 16'h00fe);
        slot_exp = 4'hb;
        wr(7'h78, 16'h6800);
        src_q.push_back(3'h1);
        wr(7'h74, 16'h0202);
        repeat (100) @(posedge ref_clk);
        #1 cmp({19'h0, src_q.size() == 1}, 20'h1);
        pen_down_pin = 1'b1;
        drain(500);
        cmp(n_wake, 20'h1);
        pen_down_pin = 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            wr(7'h78, {k[1:0], 1'b0, k[0], 12'h000});
            cmp({16'h0, pen_detect_en, digitiser_en, panel_five_wire, switch_matrix_hold},
                {16'h0, k != 0, k == 3, k[0], k == 3});
        end
        wr(7'h78, 16'h0000);
        // continuous at the fastest rate, stopped by clearing the mode bit
        wr(7'h76, 16'h03fe);
        for (k = 0; k < 6; k = k + 1) src_q.push_back(3'h1);
        wr(7'h74, 16'h0102);
        i = 0;
        while (src_q.size() > 1 && i < 3000) begin
            @(posedge ref_clk);
            i = i + 1;
        end
        #1 cmp({19'h0, src_q.size() <= 1}, 20'h1);
        wr(7'h74, 16'h0000);
        repeat (100) @(posedge ref_clk);
        #1 cmp({18'h0, src_q.size() == 0, val_q.size() == 0}, 20'h3);
        report_and_stop;
    end
endmodule
bind touchpanel_measure_control touch_asserts chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .switch_matrix_hold(switch_matrix_hold), .panel_five_wire(panel_five_wire),
    .pen_detect_en(pen_detect_en), .digitiser_en(digitiser_en), .wake_link(wake_link),
    .wake_device(wake_device), .slot_valid(slot_valid), .slot_number(slot_number),
    .slot_data(slot_data));
